// *** sbc_flag_map.svh ***
// Register offsets, field positions, reset values and timing of the flag bank
`ifndef SBC_FLAG_MAP_SVH
`define SBC_FLAG_MAP_SVH

// ****************************************
// Register offsets (7-bit SPI address)
// ****************************************
`define ADDR_THERMAL 7'h42
`define ADDR_DEVICE 7'h43
`define ADDR_BUS 7'h44

// ****************************************
// Field positions
// ****************************************
`define THERM_PREWARN_BIT 0
`define THERM_SHUTDOWN1_BIT 1
`define THERM_SHUTDOWN2_BIT 2
`define DEV_FAILURE_BIT 0
`define DEV_SPI_FAIL_BIT 1
`define DEV_WD_LSB 2
`define DEV_CAUSE_LSB 6
`define BUS_CAN_SUPPLY_UNDERVOLTAGE_FLAG_BIT 0
`define BUS_CAN_FAIL_LSB 1
`define BUS_SELECTIVE_WAKE_SYSTEM_ERROR_BIT 3
`define BUS_CAN_TIMEOUT_FLAG_BIT 4

// ****************************************
// Reset values and frame format
// ****************************************
`define RESET_THERMAL 8'h00
`define RESET_DEVICE 8'h00
`define RESET_BUS 8'h00
`define FRAME_BITS 5'h10
`define ADDR_BITS 5'h07
`define MODE_BITS 5'h08

// ****************************************
// Timing
// ****************************************
`define CLOCK_PERIOD_NS 10
`define TX_ENABLE_TIME_NS 4000
`define TX_ENABLE_CYCLES \
	(((`TX_ENABLE_TIME_NS) + (`CLOCK_PERIOD_NS) - 1) / (`CLOCK_PERIOD_NS))

`endif

// *** sbc_flag_pkg.sv ***
// Types shared by the status flag bank
package sbc_flag_pkg;

	typedef logic [7:0] byte_t;

	typedef enum logic [1:0] {
		CAUSE_CLEARED,
		CAUSE_FAILURE,
		CAUSE_SLEEP,
		CAUSE_RESERVED
	} cause_e;

	typedef enum logic [1:0] {
		CAN_OK,
		CAN_THERMAL,
		CAN_TXD_DOM,
		CAN_BUS_DOM
	} can_fail_e;

	typedef enum logic [1:0] {
		TX_ON,
		TX_FAULT,
		TX_WAIT
	} tx_state_e;

endpackage

// *** sbc_sync_bits.sv ***
// Two-flip-flop synchroniser, one chain per bit
`timescale 1ns/1ps
module sbc_sync_bits #(
	parameter int WIDTH = 1
) (
	input wire logic clock,
	input wire logic resetn,
	input wire logic [WIDTH-1:0] async,
	output logic [WIDTH-1:0] synced
);

	logic [WIDTH-1:0] meta_q;

	genvar i;
	generate
		for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
			always_ff @(posedge clock or negedge resetn) begin
				if (!resetn) begin
					meta_q[i] <= 1'b0;
					synced[i] <= 1'b0;
				end else begin
					meta_q[i] <= async[i];
					synced[i] <= meta_q[i];
				end
			end
		end
	endgenerate

endmodule

// *** sbc_spi_frame.sv ***
// SPI frame receiver: 16-bit LSB-first frames, address byte then data byte
`timescale 1ns/1ps
`include "sbc_flag_map.svh"
module sbc_spi_frame
	import sbc_flag_pkg::*;
(
	input wire logic clock,
	input wire logic resetn,
	input wire logic sclkSync,
	input wire logic csnSync,
	input wire logic mosiSync,
	input wire byte_t txByte,
	output logic [6:0] frameAddr,
	output logic frameClear,
	output logic frameDone,
	output logic frameValid,
	output logic miso
);

	logic sclkPrev_q;
	logic csnPrev_q;
	logic [15:0] shift_q;
	logic [4:0] count_q;
	byte_t tx_q;
	logic sclkRise;
	logic sclkFall;

	assign sclkRise = sclkSync & ~sclkPrev_q;
	assign sclkFall = ~sclkSync & sclkPrev_q;

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			sclkPrev_q <= 1'b0;
			csnPrev_q <= 1'b1;
		end else begin
			sclkPrev_q <= sclkSync;
			csnPrev_q <= csnSync;
		end
	end

	// Bits arrive LSB first: 7 address bits, access mode, then data
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			shift_q <= 16'h0000;
			count_q <= 5'h00;
			frameAddr <= 7'h00;
			frameClear <= 1'b0;
		end else if (csnSync) begin
			count_q <= 5'h00;
		end else if (sclkRise) begin
			shift_q <= {mosiSync, shift_q[15:1]};
			if (count_q <= `FRAME_BITS)
				count_q <= count_q + 5'h01;
			if (count_q == `ADDR_BITS) begin
				frameAddr <= shift_q[15:9];
				frameClear <= mosiSync;
			end
		end
	end

	// Register contents go out in the data byte of the same frame
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			tx_q <= 8'h00;
			miso <= 1'b0;
		end else if (csnSync) begin
			miso <= 1'b0;
		end else if (sclkFall) begin
			if (count_q == `MODE_BITS) begin
				miso <= txByte[0];
				tx_q <= {1'b0, txByte[7:1]};
			end else if (count_q > `MODE_BITS) begin
				miso <= tx_q[0];
				tx_q <= {1'b0, tx_q[7:1]};
			end
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			frameDone <= 1'b0;
			frameValid <= 1'b0;
		end else begin
			frameDone <= csnSync & ~csnPrev_q & (count_q != 5'h00);
			frameValid <= count_q == `FRAME_BITS;
		end
	end

endmodule

// *** sbc_status_flag_bank.sv ***
// Status flag bank: thermal, device and bus status registers behind SPI
`timescale 1ns/1ps
`include "sbc_flag_map.svh"
module sbc_status_flag_bank
	import sbc_flag_pkg::*;
(
	input wire logic clock,
	input wire logic resetn,
	input wire logic spiClock,
	input wire logic spiSelectN,
	input wire logic spiDataIn,
	output logic spiDataOut,
	output logic spiDataOutEnable,
	input wire logic tempPrewarn,
	input wire logic tempShutdown1,
	input wire logic tempShutdown2,
	input wire logic busSilenceIndication,
	input wire logic canThermal,
	input wire logic txdDomTimeout,
	input wire logic busDomTimeout,
	input wire logic vcanBelowThreshold,
	input wire logic txdHigh,
	input wire logic softReset,
	input wire logic restartEntry,
	input wire logic restartFromFailure,
	input wire logic wakeFromFailSafe,
	input wire logic illegalSleepRequest,
	input wire logic sleepEntry,
	input wire logic sleepWithWakeFlags,
	input wire logic wdTriggerOk,
	input wire logic wdTriggerFail,
	input wire logic wdStopped,
	input wire logic wdStopByFailure,
	input wire logic [1:0] deviceConfig,
	input wire logic configSelect,
	input wire logic failOutputEvent,
	input wire logic selectiveWakeEnable,
	input wire logic swkConfigError,
	input wire logic swkCounterOverflow,
	input wire logic canModeBit1,
	input wire logic transceiverWakeOrOff,
	input wire logic modeNormalOrStop,
	input wire logic canTimeoutIrqMask,
	output logic failSafeRequest,
	output logic restartRequest,
	output logic failOutput,
	output logic canTimeoutIrq,
	output logic transmitEnable,
	output logic selectiveWakeAllowed
);

	// ****************************************
	// Pin synchronisers and SPI frame receiver
	// ****************************************
	logic [10:0] pinSync;
	logic sclkSync, csnSync, mosiSync;
	logic prewarnSync, shut1Sync, shut2Sync, silenceSync;
	logic canThermSync, txdDomSync, busDomSync, vcanLowSync;
	logic [6:0] frameAddr;
	logic frameClear, frameDone, frameValid;
	byte_t readByte;

	sbc_sync_bits #(.WIDTH(11)) u_sync (
		.clock(clock),
		.resetn(resetn),
		.async({spiClock, spiSelectN, spiDataIn, tempPrewarn,
			tempShutdown1, tempShutdown2, busSilenceIndication,
			canThermal, txdDomTimeout, busDomTimeout,
			vcanBelowThreshold}),
		.synced(pinSync)
	);

	assign {sclkSync, csnSync, mosiSync, prewarnSync, shut1Sync, shut2Sync,
		silenceSync, canThermSync, txdDomSync, busDomSync,
		vcanLowSync} = pinSync;

	sbc_spi_frame u_spi (
		.clock(clock),
		.resetn(resetn),
		.sclkSync(sclkSync),
		.csnSync(csnSync),
		.mosiSync(mosiSync),
		.txByte(readByte),
		.frameAddr(frameAddr),
		.frameClear(frameClear),
		.frameDone(frameDone),
		.frameValid(frameValid),
		.miso(spiDataOut)
	);

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn)
			spiDataOutEnable <= 1'b0;
		else
			spiDataOutEnable <= ~csnSync;
	end

	// ****************************************
	// Register clear decode
	// ****************************************
	function automatic logic clearHits(input logic [6:0] addr,
		input logic [6:0] target);
		clearHits = addr == target;
	endfunction

	logic clearStrobe;
	logic clrThermal, clrDevice, clrBus;
	logic wipe;

	// A clear takes effect only for a complete 16-bit frame with mode 1
	assign clearStrobe = frameDone & frameValid & frameClear;
	assign clrThermal = clearStrobe & clearHits(frameAddr, `ADDR_THERMAL);
	assign clrDevice = clearStrobe & clearHits(frameAddr, `ADDR_DEVICE);
	assign clrBus = clearStrobe & clearHits(frameAddr, `ADDR_BUS);
	assign wipe = softReset;

	// ****************************************
	// Thermal protection status
	// ****************************************
	logic [2:0] thermal_q;
	logic [2:0] thermalSet;

	assign thermalSet = {shut2Sync, shut1Sync, prewarnSync};

	// Restart entry does not touch the flags; only reset, soft reset and host clear do
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn)
			thermal_q <= 3'(`RESET_THERMAL);
		else if (wipe)
			thermal_q <= 3'h0;
		else if (clrThermal)
			thermal_q <= thermalSet;
		else
			thermal_q <= thermal_q | thermalSet;
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn)
			failSafeRequest <= 1'b0;
		else
			failSafeRequest <= shut2Sync;
	end

	// ****************************************
	// Device information status
	// ****************************************
	cause_e cause_q;
	logic [1:0] wdCount_q;
	logic spiFail_q;
	logic failure_q;
	logic wdFrozen;
	logic wdAutoClear;
	logic [1:0] wdNext;
	logic wdActivates;
	logic wdFailFlag;

	// Configurations 2 and 4 hold the counter until a good trigger
	assign wdFrozen = deviceConfig[0] & (wdCount_q != 2'h0);
	assign wdAutoClear = wdTriggerOk |
		(wdStopped & ~wdStopByFailure & ~wdFrozen);
	assign wdNext = (wdCount_q == 2'h2) ? 2'h2 : wdCount_q + 2'h1;
	// Config 2 acts on the first failure, the others on the second
	assign wdActivates = (deviceConfig == 2'h1) ?
		(wdNext == 2'h1) : (wdNext == 2'h2);
	assign wdFailFlag = wdTriggerFail & wdActivates &
		~(~configSelect & (wdNext == 2'h1));

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn)
			wdCount_q <= 2'(`RESET_DEVICE >> `DEV_WD_LSB);
		else if (wipe)
			wdCount_q <= 2'h0;
		else if (wdTriggerFail)
			wdCount_q <= wdNext;
		else if (wdAutoClear)
			wdCount_q <= 2'h0;
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn)
			restartRequest <= 1'b0;
		else
			restartRequest <= wdTriggerFail;
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn)
			cause_q <= CAUSE_CLEARED;
		else if (wipe)
			cause_q <= CAUSE_CLEARED;
		else if (restartFromFailure | wakeFromFailSafe | illegalSleepRequest)
			cause_q <= CAUSE_FAILURE;
		else if (sleepEntry | sleepWithWakeFlags)
			cause_q <= CAUSE_SLEEP;
		else if (clrDevice)
			cause_q <= CAUSE_CLEARED;
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			spiFail_q <= 1'b0;
			failure_q <= 1'b0;
		end else if (wipe) begin
			spiFail_q <= 1'b0;
			failure_q <= 1'b0;
		end else begin
			spiFail_q <= (frameDone & ~frameValid) |
				(spiFail_q & ~clrDevice);
			failure_q <= wdFailFlag | failOutputEvent |
				(failure_q & ~clrDevice);
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn)
			failOutput <= 1'b0;
		else if (wipe)
			failOutput <= 1'b0;
		else if (wdFailFlag | failOutputEvent)
			failOutput <= 1'b1;
	end

	// ****************************************
	// Bus communication status
	// ****************************************
	logic canTimeout_q;
	logic selective_wake_system_error_q;
	can_fail_e canFail_q;
	logic vcanUv_q;
	logic timeoutSet, sysErrSet, vcanSet;
	logic canFailEvent;
	can_fail_e canFailCode;

	assign timeoutSet = selectiveWakeEnable & silenceSync;
	assign sysErrSet = selectiveWakeEnable &
		(swkConfigError | swkCounterOverflow);
	assign vcanSet = canModeBit1 & vcanLowSync;
	assign canFailEvent = canThermSync | txdDomSync | busDomSync;

	always_comb begin
		if (canThermSync)
			canFailCode = CAN_THERMAL;
		else if (txdDomSync)
			canFailCode = CAN_TXD_DOM;
		else if (busDomSync)
			canFailCode = CAN_BUS_DOM;
		else
			canFailCode = CAN_OK;
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			canTimeout_q <= 1'b0;
			selective_wake_system_error_q <= 1'b0;
			vcanUv_q <= 1'b0;
		end else if (wipe) begin
			canTimeout_q <= 1'b0;
			selective_wake_system_error_q <= 1'b0;
			vcanUv_q <= 1'b0;
		end else begin
			canTimeout_q <= timeoutSet | (canTimeout_q & ~clrBus);
			selective_wake_system_error_q <= sysErrSet | (selective_wake_system_error_q & ~clrBus);
			vcanUv_q <= vcanSet | (vcanUv_q & ~clrBus);
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn)
			canFail_q <= CAN_OK;
		else if (wipe)
			canFail_q <= CAN_OK;
		else if (canFailEvent)
			canFail_q <= canFailCode;
		else if (clrBus)
			canFail_q <= CAN_OK;
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			canTimeoutIrq <= 1'b0;
			selectiveWakeAllowed <= 1'b1;
		end else begin
			canTimeoutIrq <= timeoutSet & ~canTimeout_q &
				modeNormalOrStop & canTimeoutIrqMask;
			selectiveWakeAllowed <= ~selective_wake_system_error_q;
		end
	end

	// ****************************************
	// Transmitter enable and recovery
	// ****************************************
	tx_state_e txState_q;
	logic [15:0] txCount_q;
	logic txFault;

	// Live fault conditions; all share one recovery: TXD high for TX_ENABLE_CYCLES in TX_WAIT
	assign txFault = canThermSync |
		(txdDomSync & ~transceiverWakeOrOff) |
		(busDomSync & ~transceiverWakeOrOff) | vcanSet;

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			txState_q <= TX_ON;
			txCount_q <= 16'h0000;
		end else begin
			case (txState_q)
				TX_ON: begin
					if (txFault)
						txState_q <= TX_FAULT;
				end
				TX_FAULT: begin
					txCount_q <= 16'h0000;
					if (!txFault)
						txState_q <= TX_WAIT;
				end
				TX_WAIT: begin
					if (txFault) begin
						txState_q <= TX_FAULT;
					end else if (!txdHigh) begin
						txCount_q <= 16'h0000;
					end else if (txCount_q ==
						16'(`TX_ENABLE_CYCLES - 1)) begin
						txState_q <= TX_ON;
					end else begin
						txCount_q <= txCount_q + 16'h0001;
					end
				end
				default: txState_q <= TX_ON;
			endcase
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn)
			transmitEnable <= 1'b1;
		else
			transmitEnable <= (txState_q == TX_ON) & ~txFault;
	end

	// ****************************************
	// Read multiplexer
	// ****************************************
	always_comb begin
		readByte = 8'h00;
		if (frameAddr == `ADDR_THERMAL) begin
			readByte = {5'h00, thermal_q};
		end else if (frameAddr == `ADDR_DEVICE) begin
			readByte = {cause_q, 2'h0, wdCount_q, spiFail_q, failure_q};
		end else if (frameAddr == `ADDR_BUS) begin
			readByte = {3'h0, canTimeout_q, selective_wake_system_error_q, canFail_q, vcanUv_q};
		end
	end

endmodule

// *** sbc_status_flag_bank_properties.sv ***
// Port-level checker for the status flag bank
`timescale 1ns/1ps
`include "sbc_flag_map.svh"
module sbc_status_flag_bank_properties (
	input wire logic clock,
	input wire logic resetn,
	input wire logic spiSelectN,
	input wire logic spiDataOutEnable,
	input wire logic tempShutdown2,
	input wire logic txdHigh,
	input wire logic softReset,
	input wire logic wdTriggerFail,
	input wire logic selectiveWakeEnable,
	input wire logic modeNormalOrStop,
	input wire logic canTimeoutIrqMask,
	input wire logic failSafeRequest,
	input wire logic restartRequest,
	input wire logic failOutput,
	input wire logic canTimeoutIrq,
	input wire logic transmitEnable,
	input wire logic selectiveWakeAllowed
);
	// ****************
	// Run length of transmit input high
	// ****************
	logic [9:0] highRun_q;
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			highRun_q <= 10'h000;
		end else if (!txdHigh) begin
			highRun_q <= 10'h000;
		end else if (highRun_q != 10'h3FF) begin
			highRun_q <= highRun_q + 10'h001;
		end
	end
	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);
	// ****************
	// Properties
	// ****************
	fail_safe_a: assert property (
		$rose(tempShutdown2) |-> ##[1:4] failSafeRequest)
		else $error("fail-safe request missing");
	restart_req_a: assert property (
		wdTriggerFail |=> restartRequest)
		else $error("restart request missing");
	irq_pulse_a: assert property (
		canTimeoutIrq |=> !canTimeoutIrq)
		else $error("timeout interrupt too long");
	irq_gate_a: assert property (
		canTimeoutIrq |-> canTimeoutIrqMask && modeNormalOrStop)
		else $error("timeout interrupt while masked");
	fail_hold_a: assert property (
		failOutput && !softReset |=> failOutput)
		else $error("fail output dropped");
	soft_clear_a: assert property (
		softReset |=> !failOutput)
		else $error("fail output kept over soft reset");
	swk_block_a: assert property (
		$fell(selectiveWakeAllowed) |-> selectiveWakeEnable)
		else $error("system error set while disabled");
	tx_wait_a: assert property (
		$rose(transmitEnable) |-> highRun_q >= `TX_ENABLE_CYCLES - 2)
		else $error("transmitter enabled too early");
	miso_idle_a: assert property (
		spiSelectN [*6] |-> !spiDataOutEnable)
		else $error("data out enabled while deselected");
endmodule

bind sbc_status_flag_bank sbc_status_flag_bank_properties
	sbc_status_flag_bank_properties_i (.clock, .resetn, .spiSelectN,
	.spiDataOutEnable, .tempShutdown2, .txdHigh, .softReset,
	.wdTriggerFail, .selectiveWakeEnable, .modeNormalOrStop,
	.canTimeoutIrqMask, .failSafeRequest, .restartRequest, .failOutput,
	.canTimeoutIrq, .transmitEnable, .selectiveWakeAllowed);

// *** sbc_spi_host.sv ***
// SPI master model of the host microcontroller
`timescale 1ns/1ps
module sbc_spi_host
	import sbc_flag_pkg::*;
(
	input wire logic clock,
	output logic spiClock,
	output logic spiSelectN,
	output logic spiDataIn,
	input wire logic spiDataOut
);
	initial begin
		spiClock = 1'b0;
		spiSelectN = 1'b1;
		spiDataIn = 1'b0;
	end
	task automatic waitClk(input int n);
		repeat (n) @(negedge clock);
	endtask
	// Address, mode bit, then data byte, LSB first; clock idles low
	task automatic xfer(input logic [6:0] addr, input logic clr,
		input int nBits, output byte_t rdata);
		logic [15:0] word;
		word = {8'h00, clr, addr};
		rdata = 8'h00;
		spiSelectN = 1'b0;
		waitClk(5);
		for (int i = 0; i < nBits; i++) begin
			spiDataIn = word[i % 16];
			waitClk(5);
			if (i >= 8 && i < 16) rdata[i - 8] = spiDataOut;
			spiClock = 1'b1;
			waitClk(5);
			spiClock = 1'b0;
		end
		waitClk(5);
		spiSelectN = 1'b1;
		// Released line shows the inverse of its last value
		spiDataIn = ~spiDataIn;
		waitClk(8);
	endtask
endmodule

// *** sbc_status_flag_bank_tb_top.sv ***
// Testbench for the status flag bank
`timescale 1ns/1ps
`include "sbc_flag_map.svh"
module sbc_status_flag_bank_tb_top
	import sbc_flag_pkg::*;
;
	logic clock, resetn, spiClock, spiSelectN, spiDataIn;
	logic spiDataOut, spiDataOutEnable, txdHigh, configSelect;
	logic selectiveWakeEnable, canModeBit1, modeNormalOrStop;
	logic canTimeoutIrqMask, failSafeRequest, restartRequest;
	logic failOutput, canTimeoutIrq, transmitEnable, selectiveWakeAllowed;
	logic [1:0] deviceConfig;
	logic [22:0] ev;
	byte_t rd;
	int errCount = 0;
	int checkCount = 0;
	int irqCount = 0;
	sbc_status_flag_bank sbc_status_flag_bank_i (.clock(clock),
		.resetn(resetn), .spiClock(spiClock), .spiSelectN(spiSelectN),
		.spiDataIn(spiDataIn), .spiDataOut(spiDataOut),
		.spiDataOutEnable(spiDataOutEnable), .tempPrewarn(ev[0]),
		.tempShutdown1(ev[1]), .tempShutdown2(ev[2]),
		.restartFromFailure(ev[3]), .wakeFromFailSafe(ev[4]),
		.illegalSleepRequest(ev[5]), .sleepEntry(ev[6]),
		.sleepWithWakeFlags(ev[7]), .softReset(ev[8]),
		.restartEntry(ev[9]), .wdTriggerOk(ev[10]),
		.wdTriggerFail(ev[11]), .wdStopped(ev[12]),
		.busSilenceIndication(ev[13]), .swkConfigError(ev[14]),
		.canThermal(ev[15]), .txdDomTimeout(ev[16]),
		.busDomTimeout(ev[17]), .vcanBelowThreshold(ev[18]),
		.txdHigh(txdHigh), .wdStopByFailure(ev[19]),
		.deviceConfig(deviceConfig), .configSelect(configSelect),
		.failOutputEvent(ev[20]), .selectiveWakeEnable(selectiveWakeEnable),
		.swkCounterOverflow(ev[21]), .canModeBit1(canModeBit1),
		.transceiverWakeOrOff(ev[22]), .modeNormalOrStop(modeNormalOrStop),
		.canTimeoutIrqMask(canTimeoutIrqMask),
		.failSafeRequest(failSafeRequest), .restartRequest(restartRequest),
		.failOutput(failOutput), .canTimeoutIrq(canTimeoutIrq),
		.transmitEnable(transmitEnable),
		.selectiveWakeAllowed(selectiveWakeAllowed));
	sbc_spi_host sbc_spi_host_i (.clock(clock), .spiClock(spiClock),
		.spiSelectN(spiSelectN), .spiDataIn(spiDataIn),
		.spiDataOut(spiDataOut));
	// ****************
	// Tasks
	// ****************
	task automatic cmpByte(input string what, input byte_t exp,
		input byte_t got);
		checkCount++;
		if (got !== exp) begin
			errCount++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic cmpBit(input string what, input logic exp,
		input logic got);
		checkCount++;
		if (got !== exp) begin
			errCount++;
			$display("[FAIL] %s expected %b seen %b", what, exp, got);
		end
	endtask
	task automatic readReg(input logic [6:0] a, input byte_t exp);
		sbc_spi_host_i.xfer(a, 1'b0, 16, rd);
		cmpByte($sformatf("register %h", a), exp, rd);
	endtask
	task automatic clearReg(input logic [6:0] a);
		sbc_spi_host_i.xfer(a, 1'b1, 16, rd);
	endtask
	// Raise one event input for n cycles, then let it settle
	task automatic hold(input int k, input int n);
		ev[k] = 1'b1;
		repeat (n) @(negedge clock);
		ev[k] = 1'b0;
		repeat (6) @(negedge clock);
	endtask
	task automatic closeOut();
		if (errCount == 0 && checkCount > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// ****************
	// Clock, monitor and watchdog
	// ****************
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	always @(posedge clock) if (canTimeoutIrq === 1'b1) irqCount++;
	initial begin
		repeat (100000) @(posedge clock);
		errCount++;
		closeOut();
	end
	// ****************
	// Main sequence
	// ****************
	initial begin
		resetn = 1'b0;
		ev = '0;
		txdHigh = 1'b1;
		deviceConfig = 2'h0;
		configSelect = 1'b1;
		selectiveWakeEnable = 1'b0;
		canModeBit1 = 1'b0;
		modeNormalOrStop = 1'b1;
		canTimeoutIrqMask = 1'b1;
		repeat (4) @(negedge clock);
		resetn = 1'b1;
		repeat (4) @(negedge clock);
		for (int a = 'h42; a <= 'h45; a++) readReg(7'(a), 8'h00);
		cmpBit("transmitEnable", 1'b1, transmitEnable);
		for (int k = 0; k < 3; k++) hold(k, 10);
		readReg(`ADDR_THERMAL, 8'h07);
		hold(9, 1);
		readReg(`ADDR_THERMAL, 8'h07);
		clearReg(`ADDR_THERMAL);
		readReg(`ADDR_THERMAL, 8'h00);
		ev[0] = 1'b1;
		clearReg(`ADDR_THERMAL);
		ev[0] = 1'b0;
		readReg(`ADDR_THERMAL, 8'h01);
		clearReg(`ADDR_THERMAL);
		for (int k = 3; k < 8; k++) begin
			hold(k, 1);
			readReg(`ADDR_DEVICE, k < 6 ? 8'h40 : 8'h80);
			clearReg(`ADDR_DEVICE);
		end
		readReg(`ADDR_DEVICE, 8'h00);
		hold(11, 1);
		readReg(`ADDR_DEVICE, 8'h04);
		cmpBit("failOutput", 1'b0, failOutput);
		hold(11, 1);
		hold(11, 1);
		readReg(`ADDR_DEVICE, 8'h09);
		hold(10, 1);
		readReg(`ADDR_DEVICE, 8'h01);
		clearReg(`ADDR_DEVICE);
		cmpBit("failOutput", 1'b1, failOutput);
		hold(8, 1);
		cmpBit("failOutput", 1'b0, failOutput);
		deviceConfig = 2'h1;
		configSelect = 1'b0;
		hold(11, 1);
		hold(12, 1);
		readReg(`ADDR_DEVICE, 8'h04);
		cmpBit("failOutput", 1'b0, failOutput);
		hold(10, 1);
		deviceConfig = 2'h0;
		hold(11, 1);
		hold(12, 1);
		readReg(`ADDR_DEVICE, 8'h00);
		// Stop caused by a watchdog failure keeps the counter
		ev[19] = 1'b1;
		hold(11, 1);
		hold(12, 1);
		ev[19] = 1'b0;
		readReg(`ADDR_DEVICE, 8'h04);
		hold(10, 1);
		hold(20, 1);
		readReg(`ADDR_DEVICE, 8'h01);
		cmpBit("failOutput", 1'b1, failOutput);
		clearReg(`ADDR_DEVICE);
		hold(8, 1);
		sbc_spi_host_i.xfer(`ADDR_THERMAL, 1'b1, 12, rd);
		readReg(`ADDR_DEVICE, 8'h02);
		clearReg(`ADDR_DEVICE);
		readReg(`ADDR_DEVICE, 8'h00);
		hold(13, 10);
		readReg(`ADDR_BUS, 8'h00);
		selectiveWakeEnable = 1'b1;
		hold(13, 10);
		hold(14, 10);
		readReg(`ADDR_BUS, 8'h18);
		cmpBit("timeout irq", 1'b1, irqCount == 1);
		cmpBit("swkAllowed", 1'b0, selectiveWakeAllowed);
		clearReg(`ADDR_BUS);
		readReg(`ADDR_BUS, 8'h00);
		hold(21, 10);
		readReg(`ADDR_BUS, 8'h08);
		clearReg(`ADDR_BUS);
		canModeBit1 = 1'b1;
		for (int k = 0; k < 4; k++) begin
			txdHigh = 1'b0;
			hold(15 + k, 10);
			cmpBit("transmitEnable", 1'b0, transmitEnable);
			txdHigh = 1'b1;
			repeat (380) @(negedge clock);
			cmpBit("transmitEnable", 1'b0, transmitEnable);
			repeat (40) @(negedge clock);
			cmpBit("transmitEnable", 1'b1, transmitEnable);
			readReg(`ADDR_BUS, k == 3 ? 8'h01 : 8'(2 * (k + 1)));
			clearReg(`ADDR_BUS);
		end
		// Wake-capable transceiver: timeout is flagged, transmitter stays on
		ev[22] = 1'b1;
		txdHigh = 1'b0;
		hold(16, 10);
		cmpBit("transmitEnable", 1'b1, transmitEnable);
		ev[22] = 1'b0;
		txdHigh = 1'b1;
		readReg(`ADDR_BUS, 8'h04);
		clearReg(`ADDR_BUS);
		canModeBit1 = 1'b0;
		hold(18, 10);
		readReg(`ADDR_BUS, 8'h00);
		closeOut();
	end
endmodule
